//--- hdl/msw_regs.vh
`ifndef MSW_REGS_VH
`define MSW_REGS_VH
// ****************************************************
// register byte offsets
// ****************************************************
`define MSW_A_DATA      8'h00
`define MSW_A_ERR       8'h04
`define MSW_A_CNT       8'h08
`define MSW_A_SNUM      8'h0C
`define MSW_A_CLO       8'h10
`define MSW_A_CHI       8'h14
`define MSW_A_DH        8'h18
`define MSW_A_STAT      8'h1C
`define MSW_A_CFG       8'h20
`define MSW_A_PROG      8'h24
// ****************************************************
// opcode, status and error fields
// ****************************************************
`define MSW_OPC_WRMULT  8'hC5
`define MSW_ST_BSY      8'h80
`define MSW_ST_DEVICE_READY_FLAG     8'h40
`define MSW_ST_DF       8'h20
`define MSW_ST_DRQ      8'h08
`define MSW_ST_ERR      8'h01
`define MSW_ER_WP       8'h40
`define MSW_ER_MC       8'h20
`define MSW_ER_ADDRESS_NOT_FOUND_BIT     8'h10
`define MSW_ER_MCR      8'h08
`define MSW_ER_ABORTED_BIT     8'h04
`define MSW_ER_NM       8'h02
`define MSW_DH_LBA      6
// ****************************************************
// configuration fields and reset values
// ****************************************************
`define MSW_CFG_EN      8
`define MSW_CFG_PKT     9
`define MSW_CFG_GEO     10
`define MSW_CFG_RST     11'h110
`define MSW_CNT_RST     8'h01
`define MSW_SNUM_RST    8'h01
`define MSW_TF_RST      8'h00
`define MSW_ERR_RST     8'h00
`define MSW_RESP_OKAY   2'h0
`define MSW_RESP_SLVERR 2'h2
`endif

//--- hdl/msw_top.v
// Function
// R1 - accept C5h, abort if packet set
// R2 - host writes sector words through data port
// R3 - count 00h means 256 sectors
// R4 - four registers form 28-bit address
// R5 - device/head bit 6 selects LBA
// R6 - success: only ready set, select kept
// R7 - error loads failing sector address
// R8 - error: ready, fault if fault, error
// R9 - report media change, then forget it
// R10 - change request cleared by media access
// R11 - address not found or out of range
// R12 - abort unsupported or uncompletable command
// R13 - write protect and no media bits
// R14 - host needs multiple mode set first
// R15 - one interrupt per block of sectors
// R16 - data request only at block start; the code sets DRQ before every sector of the block
// R17 - count is sectors, not blocks
// R18 - final partial block gets remainder
// R19 - abort when multiple mode disabled
// R20 - stop at failing sector, no more
// R21 - host retries singly for error details
// R22 - interrupt with each block data request
// R23 - host polls until busy clear
// R24 - busy or data request until done
// R25 - remaining and within-block sector counters
`timescale 1ns/100ps
`default_nettype none
`include "msw_regs.vh"
module msw_top
#(
   parameter [8:0]  SECTOR_WORDS = 9'h100,
   parameter [27:0] MAX_LBA      = 28'hFFFFFFF
)
(
   input  wire        CLK,
   input  wire        RESET_N,
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   output reg         INTRQ,
   output reg         MEDIA_WSTB,
   output reg  [15:0] MEDIA_WDATA,
   output reg  [27:0] MEDIA_ADDR,
   output reg         MEDIA_REQ,
   input  wire        MEDIA_DONE,
   input  wire        MEDIA_ERR,
   input  wire        MEDIA_FAULT,
   input  wire        MEDIA_CHANGED,
   input  wire        MEDIA_CHG_REQ,
   input  wire        MEDIA_WPROT,
   input  wire        MEDIA_ABSENT
);

// ****************************************************
// functions and states
// ****************************************************
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_DRQ  = 4'b0010;
localparam [3:0] ST_CMT  = 4'b0100;
localparam [3:0] ST_REL  = 4'b1000;

function msw_mapped;
   input [7:0] a;
   begin
      msw_mapped = (a[1:0] == 2'b00) && (a <= `MSW_A_PROG);
   end
endfunction

// sectors in the next block: block count or what is left
function [7:0] msw_blk_len;
   input [8:0] rem;
   input [7:0] blk;
   begin
      if (rem < {1'b0, blk})
         msw_blk_len = rem[7:0];
      else
         msw_blk_len = blk;
   end
endfunction

// ****************************************************
// pin synchronisers
// ****************************************************
reg  [6:0] sync1_ff;
reg  [6:0] sync2_ff;
reg  [1:0] prev_ff;
wire       done_s = sync2_ff[0];
wire       err_s  = sync2_ff[1];
wire       flt_s  = sync2_ff[2];
wire       wp_s   = sync2_ff[5];
wire       nm_s   = sync2_ff[6];
wire       mc_rise  = sync2_ff[3] & ~prev_ff[0];
wire       mcr_rise = sync2_ff[4] & ~prev_ff[1];

always @(posedge CLK)
begin
   if (!RESET_N)
   begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
      prev_ff  <= 2'h0;
   end
   else
   begin
      sync1_ff <= {MEDIA_ABSENT, MEDIA_WPROT, MEDIA_CHG_REQ, MEDIA_CHANGED,
                   MEDIA_FAULT, MEDIA_ERR, MEDIA_DONE};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[4:3];
   end
end

// ****************************************************
// state and task file registers
// ****************************************************
reg  [3:0]  state_ff;
reg  [7:0]  err_ff;
reg  [7:0]  cnt_ff;
reg  [7:0]  snum_ff;
reg  [7:0]  clo_ff;
reg  [7:0]  chi_ff;
reg  [7:0]  dh_ff;
reg  [7:0]  stat_ff;
reg  [10:0] cfg_ff;
reg  [8:0]  rem_ff;
reg  [7:0]  within_ff;
reg  [8:0]  wcnt_ff;
reg         mc_pend_ff;
reg         mcr_pend_ff;
reg         merr_ff;
reg         mflt_ff;

// ****************************************************
// AXI4-Lite slave
// ****************************************************
reg  [7:0]  aw_addr_ff;
reg         aw_full_ff;
reg         w_full_ff;
reg  [31:0] w_data_ff;
reg  [3:0]  w_strb_ff;
reg  [7:0]  ar_addr;
reg  [31:0] nxt_rdata;
wire        aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
wire        w_hs  = S_AXI_WVALID & S_AXI_WREADY;
wire        ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
wire        in_sector = (state_ff == ST_CMT) | (state_ff == ST_REL);
// data words stall while a sector is being committed
wire        wr_stall = (aw_addr_ff == `MSW_A_DATA) & in_sector;
wire        wr_go = aw_full_ff & w_full_ff & ~S_AXI_BVALID & ~wr_stall;
wire        stat_rd = ar_hs & (S_AXI_ARADDR == `MSW_A_STAT);

always @(posedge CLK)
begin
   if (!RESET_N)
   begin
      aw_addr_ff    <= 8'h00;
      aw_full_ff    <= 1'b0;
      w_full_ff     <= 1'b0;
      w_data_ff     <= 32'h00000000;
      w_strb_ff     <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `MSW_RESP_OKAY;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `MSW_RESP_OKAY;
   end
   else
   begin
      if (aw_hs)
      begin
         aw_addr_ff <= S_AXI_AWADDR;
         aw_full_ff <= 1'b1;
      end
      else if (wr_go)
         aw_full_ff <= 1'b0;
      if (w_hs)
      begin
         w_data_ff <= S_AXI_WDATA;
         w_strb_ff <= S_AXI_WSTRB;
         w_full_ff <= 1'b1;
      end
      else if (wr_go)
         w_full_ff <= 1'b0;
      S_AXI_AWREADY <= ~(aw_hs | (aw_full_ff & ~wr_go));
      S_AXI_WREADY  <= ~(w_hs | (w_full_ff & ~wr_go));
      if (wr_go)
      begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= msw_mapped(aw_addr_ff) ? `MSW_RESP_OKAY : `MSW_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
         S_AXI_BVALID <= 1'b0;
      S_AXI_ARREADY <= ~(ar_hs | (S_AXI_RVALID & ~S_AXI_RREADY));
      if (ar_hs)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA  <= nxt_rdata;
         S_AXI_RRESP  <= msw_mapped(S_AXI_ARADDR) ? `MSW_RESP_OKAY : `MSW_RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end
end

always @*
begin
   ar_addr = S_AXI_ARADDR;
   case (ar_addr)
      `MSW_A_ERR:  nxt_rdata = {24'h000000, err_ff};
      `MSW_A_CNT:  nxt_rdata = {24'h000000, cnt_ff};
      `MSW_A_SNUM: nxt_rdata = {24'h000000, snum_ff};
      `MSW_A_CLO:  nxt_rdata = {24'h000000, clo_ff};
      `MSW_A_CHI:  nxt_rdata = {24'h000000, chi_ff};
      `MSW_A_DH:   nxt_rdata = {24'h000000, dh_ff};
      `MSW_A_STAT: nxt_rdata = {24'h000000, stat_ff};
      `MSW_A_CFG:  nxt_rdata = {21'h00000, cfg_ff};
      `MSW_A_PROG: nxt_rdata = {4'h0, state_ff, 7'h00, within_ff, rem_ff};
      default:     nxt_rdata = 32'h00000000;
   endcase
end

// ****************************************************
// command decode
// ****************************************************
wire       tf_wr  = wr_go & w_strb_ff[0] & (state_ff == ST_IDLE);
wire       cmd_go = tf_wr & (aw_addr_ff == `MSW_A_STAT);
// R1 single opcode
wire       opc_ok = (w_data_ff[7:0] == `MSW_OPC_WRMULT);
// R5 addressing mode
wire       lba_mode = dh_ff[`MSW_DH_LBA];
// R4 start address
wire [27:0] start_a = {dh_ff[3:0], chi_ff, clo_ff, snum_ff};
// R3 zero means 256
wire [8:0]  total = (cnt_ff == 8'h00) ? 9'h100 : {1'b0, cnt_ff};
wire [28:0] end_a = {1'b0, start_a} + {20'h00000, total};
wire        oor   = end_a > ({1'b0, MAX_LBA} + 29'h0000001);
// R1 R12 R19 abort cases
wire        e_aborted_bit = ~opc_ok | cfg_ff[`MSW_CFG_PKT] | ~cfg_ff[`MSW_CFG_EN] | (cfg_ff[7:0] == 8'h00);
// R11 unknown address
wire        e_address_not_found_bit = opc_ok & (lba_mode ? oor : cfg_ff[`MSW_CFG_GEO]);
wire        mc_clr = cmd_go & opc_ok;
// R9 R10 R13 media condition bits
wire [7:0]  cmd_err = (e_aborted_bit ? `MSW_ER_ABORTED_BIT : 8'h00)
                    | (e_address_not_found_bit ? `MSW_ER_ADDRESS_NOT_FOUND_BIT : 8'h00)
                    | ((opc_ok & nm_s) ? `MSW_ER_NM : 8'h00)
                    | ((opc_ok & wp_s & ~nm_s) ? `MSW_ER_WP : 8'h00)
                    | ((opc_ok & mc_pend_ff) ? `MSW_ER_MC : 8'h00)
                    | ((opc_ok & mcr_pend_ff) ? `MSW_ER_MCR : 8'h00);
wire        dat_wr = wr_go & (aw_addr_ff == `MSW_A_DATA) & (state_ff == ST_DRQ);
wire        last_w = (wcnt_ff == SECTOR_WORDS - 9'h001);
wire [8:0]  rem_nx = rem_ff - 9'h001;

// ****************************************************
// execution engine
// ****************************************************
always @(posedge CLK)
begin
   if (!RESET_N)
   begin
      state_ff    <= ST_IDLE;
      err_ff      <= `MSW_ERR_RST;
      cnt_ff      <= `MSW_CNT_RST;
      snum_ff     <= `MSW_SNUM_RST;
      clo_ff      <= `MSW_TF_RST;
      chi_ff      <= `MSW_TF_RST;
      dh_ff       <= `MSW_TF_RST;
      stat_ff     <= `MSW_ST_DEVICE_READY_FLAG;
      cfg_ff      <= `MSW_CFG_RST;
      rem_ff      <= 9'h000;
      within_ff   <= 8'h00;
      wcnt_ff     <= 9'h000;
      mc_pend_ff  <= 1'b0;
      mcr_pend_ff <= 1'b0;
      merr_ff     <= 1'b0;
      mflt_ff     <= 1'b0;
      INTRQ       <= 1'b0;
      MEDIA_WSTB  <= 1'b0;
      MEDIA_WDATA <= 16'h0000;
      MEDIA_ADDR  <= 28'h0000000;
      MEDIA_REQ   <= 1'b0;
   end
   else
   begin
      MEDIA_WSTB <= 1'b0;
      // new events win over the clear
      mc_pend_ff  <= mc_rise | (mc_pend_ff & ~mc_clr);
      mcr_pend_ff <= mcr_rise | (mcr_pend_ff & ~mc_clr);
      INTRQ <= INTRQ & ~stat_rd;
      if (tf_wr)
      begin
         case (aw_addr_ff)
            `MSW_A_CNT:  cnt_ff  <= w_data_ff[7:0];
            `MSW_A_SNUM: snum_ff <= w_data_ff[7:0];
            `MSW_A_CLO:  clo_ff  <= w_data_ff[7:0];
            `MSW_A_CHI:  chi_ff  <= w_data_ff[7:0];
            `MSW_A_DH:   dh_ff   <= w_data_ff[7:0];
            `MSW_A_CFG:  cfg_ff  <= {w_data_ff[10:8] & {3{w_strb_ff[1]}}, w_data_ff[7:0]}
                                  | {cfg_ff[10:8] & {3{~w_strb_ff[1]}}, 8'h00};
            default:     cfg_ff  <= cfg_ff;
         endcase
      end
      case (state_ff)
         ST_IDLE:
         begin
            if (cmd_go)
            begin
               INTRQ <= 1'b1;
               if (cmd_err != 8'h00)
               begin
                  // R8 error completion image
                  err_ff  <= cmd_err;
                  stat_ff <= `MSW_ST_DEVICE_READY_FLAG | `MSW_ST_ERR;
               end
               else
               begin
                  // R17 R25 sector counters loaded
                  err_ff     <= 8'h00;
                  rem_ff     <= total;
                  within_ff  <= msw_blk_len(total, cfg_ff[7:0]);
                  wcnt_ff    <= 9'h000;
                  MEDIA_ADDR <= start_a;
                  // R22 data request opens first block
                  stat_ff  <= `MSW_ST_DEVICE_READY_FLAG | `MSW_ST_DRQ;
                  state_ff <= ST_DRQ;
               end
            end
         end
         ST_DRQ:
         begin
            // R2 data word from host
            if (dat_wr)
            begin
               MEDIA_WSTB  <= 1'b1;
               MEDIA_WDATA <= w_data_ff[15:0];
               wcnt_ff     <= wcnt_ff + 9'h001;
               if (last_w)
               begin
                  // R24 busy rises as request drops
                  stat_ff   <= `MSW_ST_BSY | `MSW_ST_DEVICE_READY_FLAG;
                  MEDIA_REQ <= 1'b1;
                  state_ff  <= ST_CMT;
               end
            end
         end
         ST_CMT:
         begin
            if (done_s)
            begin
               MEDIA_REQ <= 1'b0;
               merr_ff   <= err_s;
               mflt_ff   <= flt_s;
               state_ff  <= ST_REL;
            end
         end
         ST_REL:
         begin
            if (~done_s)
            begin
               wcnt_ff <= 9'h000;
               if (merr_ff | mflt_ff)
               begin
                  // R7 R20 stop at failing sector
                  snum_ff     <= MEDIA_ADDR[7:0];
                  clo_ff      <= MEDIA_ADDR[15:8];
                  chi_ff      <= MEDIA_ADDR[23:16];
                  dh_ff[3:0]  <= MEDIA_ADDR[27:24];
                  // R8 R12 fault flag only for fault
                  err_ff   <= `MSW_ER_ABORTED_BIT;
                  stat_ff  <= `MSW_ST_DEVICE_READY_FLAG | `MSW_ST_ERR | (mflt_ff ? `MSW_ST_DF : 8'h00);
                  INTRQ    <= 1'b1;
                  state_ff <= ST_IDLE;
               end
               else if (rem_ff == 9'h001)
               begin
                  // R6 clean completion
                  rem_ff   <= rem_nx;
                  stat_ff  <= `MSW_ST_DEVICE_READY_FLAG;
                  INTRQ    <= 1'b1;
                  state_ff <= ST_IDLE;
               end
               else
               begin
                  // R25 counters step per sector
                  rem_ff     <= rem_nx;
                  MEDIA_ADDR <= MEDIA_ADDR + 28'h0000001;
                  stat_ff    <= `MSW_ST_DEVICE_READY_FLAG | `MSW_ST_DRQ;
                  state_ff   <= ST_DRQ;
                  if (within_ff == 8'h01)
                  begin
                     // R15 R18 R22 next or partial block
                     within_ff <= msw_blk_len(rem_nx, cfg_ff[7:0]);
                     INTRQ     <= 1'b1;
                  end
                  else
                     // R16 no request check mid block
                     within_ff <= within_ff - 8'h01;
               end
            end
         end
         default:
            state_ff <= ST_IDLE;
      endcase
   end
end

endmodule // msw_top
`default_nettype wire

//--- tb/msw_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// port checker
// ****************************************************
module msw_top_sva (
   input wire logic        CLK,
   input wire logic        RESET_N,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic [7:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic        INTRQ,
   input wire logic        MEDIA_WSTB,
   input wire logic [27:0] MEDIA_ADDR,
   input wire logic        MEDIA_REQ,
   input wire logic        MEDIA_DONE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   logic stat_rd_ff;
   logic nxt_stat_rd;
   assign nxt_stat_rd = (S_AXI_ARVALID && S_AXI_ARREADY) ? (S_AXI_ARADDR == 8'h1C) : stat_rd_ff;
   always_ff @(posedge CLK)
   begin
      stat_rd_ff <= RESET_N ? nxt_stat_rd : 1'b0;
   end
   sequence s_ar_hs;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   sequence s_commit;
      MEDIA_REQ && !MEDIA_DONE;
   endsequence
   AST_RD_ANSWER: assert property (s_ar_hs |=> S_AXI_RVALID)
      else $error("read answer late");
   AST_RD_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   AST_WR_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   AST_WR_SLOT: assert property ($rose(S_AXI_BVALID) |-> !$past(S_AXI_AWREADY))
      else $error("response without a held address");
   AST_STROBE_PULSE: assert property (MEDIA_WSTB |=> !MEDIA_WSTB)
      else $error("word strobe too long");
   AST_REQ_HOLD: assert property (s_commit |=> MEDIA_REQ)
      else $error("commit request dropped early");
   AST_ADDR_STABLE: assert property (MEDIA_REQ && $past(MEDIA_REQ) |-> $stable(MEDIA_ADDR))
      else $error("sector address moved during commit");
   AST_BUSY_SHOWN: assert property ($rose(S_AXI_RVALID) && stat_rd_ff && $past(MEDIA_REQ) |-> S_AXI_RDATA[7])
      else $error("busy not shown during commit");
   AST_INTRQ_CLEAR: assert property ($fell(INTRQ) && $past(RESET_N) |-> stat_rd_ff)
      else $error("interrupt cleared without status read");
endmodule // msw_top_sva
`default_nettype wire

//--- tb/msw_media_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// media side responder, prompt and slow by turns
// ****************************************************
module msw_media_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       req,
   input  wire logic       fault_en,
   input  wire logic [7:0] fail_at,
   output logic            done,
   output logic            err,
   output logic            fault
);
   logic [7:0] idx_ff;
   logic [2:0] wait_ff;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         done    <= 1'b0;
         err     <= 1'b0;
         fault   <= 1'b0;
         idx_ff  <= 8'h00;
         wait_ff <= 3'h0;
      end
      else if (req && !done)
      begin
         wait_ff <= wait_ff + 3'h1;
         if (wait_ff == (idx_ff[0] ? 3'h5 : 3'h1))
         begin
            done    <= 1'b1;
            err     <= (idx_ff == fail_at);
            fault   <= fault_en && (idx_ff == fail_at);
            wait_ff <= 3'h0;
         end
      end
      else if (!req && done)
      begin
         done   <= 1'b0;
         err    <= ~err;
         fault  <= ~fault;
         idx_ff <= idx_ff + 8'h01;
      end
   end
endmodule // msw_media_model
`default_nettype wire

//--- tb/msw_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module msw_top_bench;
   logic        CLK, RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
   logic        MEDIA_ABSENT, fault_en, media_ev, wprot;
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, fail_at;
   logic [31:0] S_AXI_WDATA, rd;
   logic [1:0]  rsp;
   logic [27:0] base;
   wire         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, INTRQ;
   wire         MEDIA_WSTB, MEDIA_REQ, MEDIA_DONE, MEDIA_ERR, MEDIA_FAULT;
   wire [1:0]   S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0]  S_AXI_RDATA;
   wire [15:0]  MEDIA_WDATA;
   wire [27:0]  MEDIA_ADDR;
   int          error_cnt, num_checks;
   int          wstb_cnt = 0;
   msw_top #(.SECTOR_WORDS(9'h004)) u_msw_top (.CLK(CLK), .RESET_N(RESET_N),
      .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
      .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
      .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
      .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
      .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
      .S_AXI_RREADY(S_AXI_RREADY), .INTRQ(INTRQ), .MEDIA_WSTB(MEDIA_WSTB), .MEDIA_WDATA(MEDIA_WDATA),
      .MEDIA_ADDR(MEDIA_ADDR), .MEDIA_REQ(MEDIA_REQ), .MEDIA_DONE(MEDIA_DONE), .MEDIA_ERR(MEDIA_ERR),
      .MEDIA_FAULT(MEDIA_FAULT), .MEDIA_CHANGED(media_ev), .MEDIA_CHG_REQ(media_ev), .MEDIA_WPROT(wprot),
      .MEDIA_ABSENT(MEDIA_ABSENT));
   msw_media_model u_msw_media_model (.clk(CLK), .rst_n(RESET_N), .req(MEDIA_REQ), .fault_en(fault_en),
      .fail_at(fail_at), .done(MEDIA_DONE), .err(MEDIA_ERR), .fault(MEDIA_FAULT));
   // ****************************************************
   // bus tasks and checks
   // ****************************************************
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 200)
      begin
         chk("wait bound", n, 0);
         test_done();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic fin;
      n = 0;
      fin = 1'b0;
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      while (!fin && n < 200)
      begin
         @(posedge CLK);
         n++;
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
         if (n == 3) S_AXI_BREADY <= 1'b1;
         if (S_AXI_BVALID && S_AXI_BREADY)
         begin
            fin = 1'b1;
            rsp = S_AXI_BRESP;
            S_AXI_BREADY <= 1'b0;
         end
      end
      tmo(n);
   endtask
   task automatic axr(input logic [7:0] a);
      int n;
      logic fin;
      n = 0;
      fin = 1'b0;
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      while (!fin && n < 200)
      begin
         @(posedge CLK);
         n++;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
         if (n == 2) S_AXI_RREADY <= 1'b1;
         if (S_AXI_RVALID && S_AXI_RREADY)
         begin
            fin = 1'b1;
            rd = S_AXI_RDATA;
            rsp = S_AXI_RRESP;
            S_AXI_RREADY <= 1'b0;
         end
      end
      tmo(n);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      axr(a);
      chk($sformatf("reg %h", a), rd, e);
   endtask
   // one sector of words, then wait out the commit
   task automatic sec(input int s);
      int n;
      for (int w = 0; w < 4; w++) axw(8'h00, 32'h0000A000 + s * 4 + w);
      n = 0;
      while (MEDIA_REQ !== 1'b1 && n < 200)
      begin
         @(posedge CLK);
         n++;
      end
      tmo(n);
      chk("media addr", MEDIA_ADDR, base + s);
      chk("media word", MEDIA_WDATA, 16'hA003 + s * 4);
      rdc(8'h1C, 32'hC0);
      n = 0;
      // poll progress until commit is over
      do
      begin
         axr(8'h24);
         n++;
      end while (rd[27:24] != 4'h1 && rd[27:24] != 4'h2 && n < 200);
      tmo(n);
   endtask
   initial
   begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   always @(posedge CLK)
      wstb_cnt <= wstb_cnt + (MEDIA_WSTB === 1'b1);
   initial
   begin
      repeat (100000) @(posedge CLK);
      chk("watchdog", 0, 1);
      test_done();
   end
   // ****************************************************
   // scenarios
   // ****************************************************
   initial
   begin
      RESET_N = 1'b0; S_AXI_AWVALID = 1'b0; S_AXI_WVALID = 1'b0; S_AXI_BREADY = 1'b0;
      media_ev = 1'b0;
      wprot = 1'b0;
      S_AXI_ARVALID = 1'b0; S_AXI_RREADY = 1'b0; S_AXI_AWADDR = 8'h00; S_AXI_ARADDR = 8'h00;
      S_AXI_WDATA = 32'h0; MEDIA_ABSENT = 1'b0; fault_en = 1'b0; fail_at = 8'hFF; base = 28'h0;
      error_cnt = 0; num_checks = 0;
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      rdc(8'h08, 32'h01);
      rdc(8'h0C, 32'h01);
      rdc(8'h04, 32'h00);
      rdc(8'h1C, 32'h40);
      rdc(8'h20, 32'h110);
      axr(8'h28);
      chk("rresp", rsp, 2'h2);
      axw(8'h2A, 32'h0);
      chk("bresp", rsp, 2'h2);
      for (int k = 0; k < 6; k++)
      begin
         MEDIA_ABSENT <= (k == 3);
         media_ev <= (k == 4);
         wprot <= (k == 4);
         axw(8'h20, (k == 0 || k == 5) ? 32'h010 : (k == 1 ? 32'h310 : (k == 4 ? 32'h510 : 32'h110)));
         axw(8'h1C, k == 2 ? 32'h30 : 32'hC5);
         repeat (2) @(posedge CLK);
         chk("irq", INTRQ, 1'b1);
         rdc(8'h1C, 32'h41);
         rdc(8'h04, k == 3 ? 32'h02 : (k == 4 ? 32'h78 : 32'h04));
         chk("irq clear", INTRQ, 1'b0);
      end
      MEDIA_ABSENT <= 1'b0;
      // multiple mode enabled, block of two
      axw(8'h20, 32'h102);
      axw(8'h08, 32'h03);
      axw(8'h0C, 32'h10);
      axw(8'h10, 32'h20);
      axw(8'h14, 32'h30);
      axw(8'h18, 32'h55);
      axw(8'h1C, 32'hC5);
      base = 28'h5302010;
      repeat (2) @(posedge CLK);
      chk("irq", INTRQ, 1'b1);
      rdc(8'h1C, 32'h48);
      for (int s = 0; s < 3; s++)
      begin
         sec(s);
         chk("irq", INTRQ, s != 0);
         rdc(8'h1C, s == 2 ? 32'h40 : 32'h48);
      end
      axr(8'h18);
      chk("dev", rd[4], 1'b1);
      fail_at <= 8'h04;
      fault_en <= 1'b1;
      axw(8'h08, 32'h02);
      axw(8'h0C, 32'h00);
      axw(8'h10, 32'h00);
      axw(8'h14, 32'h00);
      axw(8'h18, 32'h40);
      axw(8'h1C, 32'hC5);
      base = 28'h0;
      rdc(8'h1C, 32'h48);
      sec(0);
      rdc(8'h1C, 32'h48);
      sec(1);
      chk("irq", INTRQ, 1'b1);
      rdc(8'h1C, 32'h61);
      rdc(8'h04, 32'h04);
      rdc(8'h0C, 32'h01);
      rdc(8'h18, 32'h40);
      axw(8'h08, 32'h01);
      axw(8'h1C, 32'hC5);
      base = 28'h1;
      sec(0);
      rdc(8'h1C, 32'h40);
      fault_en <= 1'b0;
      axw(8'h08, 32'h00);
      axw(8'h1C, 32'hC5);
      axr(8'h24);
      chk("remaining", rd[8:0], 9'h100);
      chk("strobes", wstb_cnt, 24);
      RESET_N <= 1'b0;
      repeat (2) @(posedge CLK);
      RESET_N <= 1'b1;
      rdc(8'h1C, 32'h40);
      test_done();
   end
endmodule // msw_top_bench
bind msw_top msw_top_sva u_msw_top_sva (.CLK(CLK), .RESET_N(RESET_N), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .INTRQ(INTRQ),
   .MEDIA_WSTB(MEDIA_WSTB), .MEDIA_ADDR(MEDIA_ADDR), .MEDIA_REQ(MEDIA_REQ), .MEDIA_DONE(MEDIA_DONE));
`default_nettype wire
